// ==== pkg/ortf_cnt_if.sv ====
`timescale 1ns/100ps
interface ortf_cnt_if;
    logic restart;
    logic [1:0] start_sel;
    logic tick;
    logic expired;
    logic running;

    modport ctrl (output restart, output start_sel, output tick, input expired, input running);
    modport cnt (input restart, input start_sel, input tick, output expired, output running);
endinterface

// ==== pkg/ortf_defs.svh ====
`ifndef ORTF_DEFS_SVH
`define ORTF_DEFS_SVH

// ==========================================================
// Oscillator ranges
`define ORTF_RANGE_MAX 3'h5
`define ORTF_RANGE_RST 3'h3

// ==========================================================
// Calibration storage reset values (factory constants)
`define ORTF_CAL_W 8
`define ORTF_CAL_HI_RST 8'h80
`define ORTF_CAL_LO_RST 8'h80

// ==========================================================
// Fault flag positions
`define ORTF_FLG_FAST_XT 0
`define ORTF_FLG_SLOW_XT 1
`define ORTF_FLG_FAST_SC 2
`define ORTF_FLG_SLOW_SC 3
`define ORTF_FLG_N 4

// ==========================================================
// Fault counter timing, in oscillator cycles
`define ORTF_FAULT_BASE_CYC 4096
`define ORTF_FAULT_SEL_W 2

`endif

// ==== pkg/ortf_pkg.sv ====
package ortf_pkg;
    typedef enum logic [2:0] {
        osc_range_bottom,
        osc_range_low,
        osc_range_mid_lo,
        osc_range_mid_hi,
        osc_range_high,
        osc_range_top
    } ortf_range_t;

    typedef enum logic [2:0] {
        slow_xtal_drive_min,
        slow_xtal_drive_1,
        slow_xtal_drive_2,
        slow_xtal_drive_max,
        slow_xtal_bypass_mode
    } ortf_slow_cfg_t;
endpackage

// ==== verif/ortf_xtal_model.sv ====
`timescale 1ns/100ps
module ortf_xtal_model (
    input wire logic clk,
    input wire logic [1:0] tick_en,
    input wire logic [1:0] slow,
    input wire logic [1:0] fault_req,
    output logic [1:0] osc_tick,
    output logic [1:0] xtal_fault_in
);
    logic phase = 1'b0;
    always_ff @(posedge clk) begin
        phase <= ~phase;
    end
    // Square-wave source: a tick every cycle, or every other cycle when slow
    assign osc_tick = tick_en & (~slow | {2{phase}});
    assign xtal_fault_in = fault_req;
endmodule

// ==== verif/osc_range_tune_fault_ctrl_tb.sv ====
`timescale 1ns/100ps
module osc_range_tune_fault_ctrl_tb;
    import ortf_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic range_wr = 1'b0, tune_wr = 1'b0, cal_wr_hi = 1'b0, cal_wr_lo = 1'b0;
    logic slow_cfg_wr = 1'b0, fast_cfg_wr = 1'b0, fast_bypass_sel = 1'b0;
    logic [2:0] range_sel = 3'h0, slow_cfg_sel = 3'h0;
    logic signed [9:0] tune_val = 10'h000;
    logic [7:0] cal_data = 8'h00;
    logic [1:0] cnt_restart = 2'h0, tick_en = 2'h0, slow = 2'h2, fault_req = 2'h0;
    logic [1:0][1:0] cnt_start_sel = 4'h0;
    logic [3:0] flag_clr = 4'h0, flag_en = 4'h0;
    logic [1:0] osc_tick, xtal_fault_in, cnt_running;
    ortf_range_t osc_range;
    ortf_slow_cfg_t slow_xtal_cfg;
    logic signed [9:0] osc_tune;
    logic [7:0] cal_hi, cal_lo;
    logic fast_xtal_bypass, fault_irq;
    logic [3:0] fault_flags;
    int bad_count = 0;
    int n_compared = 0;
    int b;
    int req_hz;
    int rng;

    ortf_ctrl #(.FAULT_BASE_CYC(4)) dut_u (.clk(clk), .rst_b(rst_b), .range_wr(range_wr),
        .range_sel(range_sel), .tune_wr(tune_wr), .tune_val(tune_val), .cal_wr_hi(cal_wr_hi),
        .cal_wr_lo(cal_wr_lo), .cal_data(cal_data), .slow_cfg_wr(slow_cfg_wr),
        .slow_cfg_sel(slow_cfg_sel), .fast_cfg_wr(fast_cfg_wr), .fast_bypass_sel(fast_bypass_sel),
        .cnt_restart(cnt_restart), .cnt_start_sel(cnt_start_sel), .osc_tick(osc_tick),
        .xtal_fault_in(xtal_fault_in), .flag_clr(flag_clr), .flag_en(flag_en), .osc_range(osc_range),
        .osc_tune(osc_tune), .cal_hi(cal_hi), .cal_lo(cal_lo), .slow_xtal_cfg(slow_xtal_cfg),
        .fast_xtal_bypass(fast_xtal_bypass), .fault_flags(fault_flags), .fault_irq(fault_irq),
        .cnt_running(cnt_running));

    ortf_xtal_model xtal_u (.clk(clk), .tick_en(tick_en), .slow(slow), .fault_req(fault_req),
        .osc_tick(osc_tick), .xtal_fault_in(xtal_fault_in));

    initial begin
        forever #5 clk = ~clk;
    end

    // ==========================================================
    // Tasks
    task automatic final_report;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Strobe mask bits: range, tune, cal hi, cal lo, slow cfg, fast cfg
    task automatic wr(input logic [5:0] m, input logic [9:0] v);
        range_sel = v[2:0];
        tune_val = v;
        cal_data = v[7:0];
        slow_cfg_sel = v[2:0];
        fast_bypass_sel = v[0];
        {fast_cfg_wr, slow_cfg_wr, cal_wr_lo, cal_wr_hi, tune_wr, range_wr} = m;
        step(1);
        {fast_cfg_wr, slow_cfg_wr, cal_wr_lo, cal_wr_hi, tune_wr, range_wr} = 6'h00;
        // Let an edge pass so a following write never re-raises a strobe in the same step
        step(1);
    endtask

    task automatic run_cnt(input int i, input int s);
        int n;
        int lim;
        n = 0;
        lim = 4 << s;
        cnt_start_sel[i] = 2'(s);
        cnt_restart[i] = 1'b1;
        step(1);
        cnt_restart = 2'h0;
        step(1);
        chk({14'h0, cnt_running}, 16'h0001 << i);
        tick_en[i] = 1'b1;
        while (n < lim) begin
            @(posedge clk);
            if (osc_tick[i]) n++;
        end
        #1;
        tick_en = 2'h0;
        chk({12'h0, fault_flags}, 16'h0000);
        step(1);
        chk({10'h0, cnt_running, fault_flags}, 16'h0004 << i);
        step(2);
        chk({12'h0, fault_flags}, 16'h0004 << i);
        flag_clr[2 + i] = 1'b1;
        step(1);
        flag_clr = 4'h0;
        chk({12'h0, fault_flags}, 16'h0000);
    endtask

    // ==========================================================
    // Tests
    initial begin
        step(16);
        rst_b = 1'b1;
        step(3);
        chk({3'h0, 3'(osc_range), osc_tune}, 16'h0c00);
        chk({cal_hi, cal_lo}, 16'h8080);
        chk(16'(slow_xtal_cfg), 16'h0003);
        chk({10'h0, fast_xtal_bypass, fault_irq, fault_flags}, 16'h0000);
        for (int r = 0; r <= 6; r++) begin
            wr(6'h02, 10'h3fb);
            chk({6'h0, osc_tune}, 16'h03fb);
            wr(6'h01, 10'(r));
            chk({3'h0, 3'(osc_range), osc_tune}, r > 5 ? 16'h17fb : 16'(r << 10));
        end
        // Host maps a custom request to the range whose span holds it, then tunes
        req_hz = 20000000;
        rng = 0;
        while (rng < 5 && req_hz >= (2000000 << rng)) rng++;
        wr(6'h01, 10'(rng));
        wr(6'h02, 10'h3f0);
        chk({3'h0, 3'(osc_range), osc_tune}, 16'h13f0);
        wr(6'h02, 10'h1ff);
        chk({6'h0, osc_tune}, 16'h01ff);
        wr(6'h03, 10'h002);
        chk({3'h0, 3'(osc_range), osc_tune}, 16'h0800);
        wr(6'h04, 10'h03c);
        chk({cal_hi, cal_lo}, 16'h3c80);
        wr(6'h08, 10'h0a5);
        chk({cal_hi, cal_lo}, 16'h3ca5);
        for (int c = 0; c <= 5; c++) begin
            wr(6'h10, 10'(c));
            chk(16'(slow_xtal_cfg), 16'(c > 4 ? 4 : c));
        end
        wr(6'h20, 10'h001);
        chk({15'h0, fast_xtal_bypass}, 16'h0001);
        for (int s = 0; s < 8; s++) run_cnt(s % 2, s / 2);
        // Fast restart in the middle of a slow count must leave the slow count alone
        slow = 2'h0;
        cnt_start_sel = 4'h0;
        cnt_restart = 2'h2;
        step(1);
        cnt_restart = 2'h0;
        tick_en = 2'h2;
        step(2);
        tick_en = 2'h0;
        cnt_restart = 2'h1;
        step(1);
        cnt_restart = 2'h0;
        tick_en = 2'h2;
        step(1);
        chk({14'h0, cnt_running}, 16'h0003);
        step(1);
        tick_en = 2'h0;
        step(1);
        chk({10'h0, cnt_running, fault_flags}, 16'h0018);
        flag_clr = 4'h8;
        step(1);
        flag_clr = 4'h0;
        chk({12'h0, fault_flags}, 16'h0000);
        fault_req = 2'h2;
        step(1);
        fault_req = 2'h0;
        step(1);
        chk({11'h0, fault_irq, fault_flags}, 16'h0002);
        flag_en = 4'h2;
        step(2);
        chk({15'h0, fault_irq}, 16'h0001);
        flag_en = 4'h1;
        step(2);
        chk({15'h0, fault_irq}, 16'h0000);
        // Host start loop: clear until the flag stays clear, with a budget
        fault_req = 2'h1;
        for (b = 0; b < 8; b++) begin
            if (b == 3) fault_req = 2'h0;
            flag_clr = 4'hf;
            step(1);
            flag_clr = 4'h0;
            step(1);
            if (fault_flags[0] === 1'b0) break;
        end
        chk(16'(b), 16'h0003);
        chk({11'h0, fault_irq, fault_flags}, 16'h0000);
        rst_b = 1'b0;
        step(2);
        rst_b = 1'b1;
        step(3);
        chk({cal_hi, cal_lo}, 16'h8080);
        chk({3'h0, 3'(osc_range), osc_tune}, 16'h0c00);
        chk(16'(slow_xtal_cfg), 16'h0003);
        chk({14'h0, cnt_running}, 16'h0000);
        final_report();
    end

    initial begin
        #100000;
        bad_count++;
        final_report();
    end
endmodule

// ==== verilog/ortf_ctrl.sv ====
// Notes on behaviour
// - Six oscillator centre ranges, each doubling, covering 1 to 64 MHz.
// - Selecting a new centre range returns the fine tuning to zero.
// - Fine tuning value is signed two's complement, negative or positive.
// - Separate calibration constants above and below 32 MHz, written independently.
// - Calibration storage holds factory constants straight after reset.
// - Fast and slow crystal fault counters start at 4096, 8192, 16384 or 32768.
// - Slow crystal: drive levels zero to three or bypass; level three at reset.
// - Bypass takes the crystal input as a square-wave clock directly.
// - A fault flag reaches the interrupt only while its enable is set.
// - Either crystal fault counter restarts alone, the other left undisturbed.
`timescale 1ns/100ps
`include "ortf_defs.svh"
module ortf_ctrl
    import ortf_pkg::*;
#(
    parameter int TUNE_W = 10,
    parameter int FAULT_BASE_CYC = `ORTF_FAULT_BASE_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic range_wr,
    input wire logic [2:0] range_sel,
    input wire logic tune_wr,
    input wire logic signed [TUNE_W-1:0] tune_val,
    input wire logic cal_wr_hi,
    input wire logic cal_wr_lo,
    input wire logic [`ORTF_CAL_W-1:0] cal_data,
    input wire logic slow_cfg_wr,
    input wire logic [2:0] slow_cfg_sel,
    input wire logic fast_cfg_wr,
    input wire logic fast_bypass_sel,
    input wire logic [1:0] cnt_restart,
    input wire logic [1:0][`ORTF_FAULT_SEL_W-1:0] cnt_start_sel,
    input wire logic [1:0] osc_tick,
    input wire logic [1:0] xtal_fault_in,
    input wire logic [`ORTF_FLG_N-1:0] flag_clr,
    input wire logic [`ORTF_FLG_N-1:0] flag_en,
    output ortf_range_t osc_range,
    output logic signed [TUNE_W-1:0] osc_tune,
    output logic [`ORTF_CAL_W-1:0] cal_hi,
    output logic [`ORTF_CAL_W-1:0] cal_lo,
    output ortf_slow_cfg_t slow_xtal_cfg,
    output logic fast_xtal_bypass,
    output logic [`ORTF_FLG_N-1:0] fault_flags,
    output logic fault_irq,
    output logic [1:0] cnt_running
);
    // ==========================================================
    // Reset release
    logic rst_meta_b;
    logic rst_sync_b;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // ==========================================================
    // Range and fine tuning
    logic range_ok;
    assign range_ok = range_sel <= `ORTF_RANGE_MAX;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_range <= ortf_range_t'(`ORTF_RANGE_RST);
        end else if (!rst_sync_b) begin
            osc_range <= ortf_range_t'(`ORTF_RANGE_RST);
        end else if (range_wr && range_ok) begin
            osc_range <= ortf_range_t'(range_sel);
        end
    end

    // A legal range write (range_sel up to ORTF_RANGE_MAX) has priority over a tune write in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_tune <= '0;
        end else if (!rst_sync_b) begin
            osc_tune <= '0;
        end else if (range_wr && range_ok) begin
            osc_tune <= '0;
        end else if (tune_wr) begin
            osc_tune <= tune_val;
        end
    end

    // ==========================================================
    // Calibration storage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cal_hi <= `ORTF_CAL_HI_RST;
            cal_lo <= `ORTF_CAL_LO_RST;
        end else if (!rst_sync_b) begin
            cal_hi <= `ORTF_CAL_HI_RST;
            cal_lo <= `ORTF_CAL_LO_RST;
        end else begin
            if (cal_wr_hi) begin
                cal_hi <= cal_data;
            end
            if (cal_wr_lo) begin
                cal_lo <= cal_data;
            end
        end
    end

    // ==========================================================
    // Crystal configuration
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            slow_xtal_cfg <= slow_xtal_drive_max;
        end else if (!rst_sync_b) begin
            slow_xtal_cfg <= slow_xtal_drive_max;
        end else if (slow_cfg_wr && slow_cfg_sel <= 3'(slow_xtal_bypass_mode)) begin
            slow_xtal_cfg <= ortf_slow_cfg_t'(slow_cfg_sel);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fast_xtal_bypass <= 1'b0;
        end else if (!rst_sync_b) begin
            fast_xtal_bypass <= 1'b0;
        end else if (fast_cfg_wr) begin
            fast_xtal_bypass <= fast_bypass_sel;
        end
    end

    // ==========================================================
    // Fault counters, index 0 fast crystal, index 1 slow crystal
    ortf_cnt_if cif [2] ();
    logic [1:0] cnt_expired;

    for (genvar i = 0; i < 2; i++) begin : g_cnt
        assign cif[i].restart = cnt_restart[i];
        assign cif[i].start_sel = cnt_start_sel[i];
        assign cif[i].tick = osc_tick[i];
        assign cnt_expired[i] = cif[i].expired;
        ortf_fault_counter #(
            .BASE_CYC(FAULT_BASE_CYC)
        ) u_cnt (
            .clk(clk),
            .rst_b(rst_sync_b),
            .cif(cif[i])
        );
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_running <= '0;
        end else begin
            cnt_running <= {cif[1].running, cif[0].running};
        end
    end

    // ==========================================================
    // Fault flags and interrupt
    logic [`ORTF_FLG_N-1:0] flag_set;
    assign flag_set[`ORTF_FLG_FAST_XT] = xtal_fault_in[0];
    assign flag_set[`ORTF_FLG_SLOW_XT] = xtal_fault_in[1];
    assign flag_set[`ORTF_FLG_FAST_SC] = cnt_expired[0];
    assign flag_set[`ORTF_FLG_SLOW_SC] = cnt_expired[1];

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_flags <= '0;
        end else if (!rst_sync_b) begin
            fault_flags <= '0;
        end else begin
            fault_flags <= (fault_flags & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_irq <= 1'b0;
        end else if (!rst_sync_b) begin
            fault_irq <= 1'b0;
        end else begin
            fault_irq <= |(fault_flags & flag_en);
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_b);

    range_legal_a: assert property (3'(osc_range) <= `ORTF_RANGE_MAX)
        else $error("oscillator range out of set");
    range_clears_tune_a: assert property (range_wr && range_ok |=> osc_tune == '0)
        else $error("tuning not cleared on range change");
    tune_load_a: assert property (tune_wr && !(range_wr && range_ok) |=> osc_tune == $past(tune_val))
        else $error("tuning value not loaded");
    cal_split_a: assert property (cal_wr_hi && !cal_wr_lo |=> cal_hi == $past(cal_data) && $stable(cal_lo))
        else $error("calibration write disturbed other range");
    cal_reset_a: assert property ($rose(rst_sync_b) |-> cal_hi == `ORTF_CAL_HI_RST && cal_lo == `ORTF_CAL_LO_RST)
        else $error("calibration not at factory value");
    drive_default_a: assert property ($rose(rst_sync_b) |-> slow_xtal_cfg == slow_xtal_drive_max)
        else $error("slow crystal not at top drive");
    fast_bypass_a: assert property (fast_cfg_wr |=> fast_xtal_bypass == $past(fast_bypass_sel))
        else $error("fast bypass not taken");
    irq_mask_a: assert property (##1 fault_irq == $past(|(fault_flags & flag_en)))
        else $error("interrupt not gated by enables");
    restart_alone_a: assert property (cnt_restart == 2'b01 && cnt_running[1] && !cnt_expired[1]
        && !(osc_tick[1]) ##1 1'b1 |=> cnt_running[1])
        else $error("restart disturbed other counter");
    flag_hold_a: assert property (fault_flags[`ORTF_FLG_SLOW_SC] && !flag_clr[`ORTF_FLG_SLOW_SC]
        |=> fault_flags[`ORTF_FLG_SLOW_SC])
        else $error("start-count flag lost");
    flag_set_a: assert property (cnt_expired[0] |=> fault_flags[`ORTF_FLG_FAST_SC])
        else $error("expiry did not set flag");
endmodule

// ==== verilog/ortf_fault_counter.sv ====
`timescale 1ns/100ps
`include "ortf_defs.svh"
module ortf_fault_counter
    import ortf_pkg::*;
#(
    parameter int BASE_CYC = `ORTF_FAULT_BASE_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    ortf_cnt_if.cnt cif
);
    localparam int CW = $clog2(BASE_CYC) + 4;
    localparam logic [CW-1:0] BASE = CW'(BASE_CYC);

    logic [CW-1:0] count;
    logic running;
    logic expired;

    assign cif.running = running;
    assign cif.expired = expired;

    // ==========================================================
    // Down counter over oscillator cycles
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (cif.restart) begin
                count <= BASE << cif.start_sel;
                running <= 1'b1;
            end else if (running && cif.tick) begin
                if (count == CW'(1)) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                    count <= '0;
                end else begin
                    count <= count - CW'(1);
                end
            end
        end
    end

    // ==========================================================
    // Checks
    start_value_a: assert property (@(posedge clk) disable iff (!rst_b)
        cif.restart |=> running && count == (BASE << $past(cif.start_sel)))
        else $error("fault counter start value wrong");
    expire_step_a: assert property (@(posedge clk) disable iff (!rst_b)
        running && cif.tick && !cif.restart && count == CW'(1) |=> expired && !running)
        else $error("fault counter did not expire");
endmodule
